/* src/prp_pkg.sv */
// Package with register map, field layout and constants of the pin remap protection block.
package prp_pkg;
    localparam int NUM_IN_SEL = 9;
    localparam int NUM_OUT_SEL = 8;
    localparam int NUM_RP = 26;
    localparam int NUM_PIN = 32;
    localparam int NUM_FUNC = 4;
    localparam int NUM_ADC = 2;
    localparam int FIELD_W = 5;

    // Byte offsets: input selects 0x00..0x20, output selects 0x40..0x5c.
    localparam logic [11:0] IN_SEL_BASE = 12'h000;
    localparam logic [11:0] OUT_SEL_BASE = 12'h040;
    localparam logic [11:0] OSC_CTRL_OFS = 12'h080;
    localparam logic [11:0] ANA_CFG0_OFS = 12'h084;
    localparam logic [11:0] ANA_CFG1_OFS = 12'h088;
    localparam logic [11:0] PULLUP_OFS = 12'h08c;
    localparam logic [11:0] FUNC_EN_BASE = 12'h090;
    localparam logic [11:0] IRQ_STAT_OFS = 12'h0a0;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h0a4;
    localparam logic [11:0] PIN_IN_OFS = 12'h0a8;

    localparam logic [15:0] IN_SEL_MASK = 16'h1f1f;
    localparam logic [15:0] IN_SEL0_MASK = 16'h1f00;
    localparam logic [15:0] IN_SEL_RST = 16'h1f1f;
    localparam logic [15:0] OUT_SEL_MASK = 16'h1f1f;
    localparam logic [15:0] OUT_SEL_RST = 16'h0000;
    localparam logic [4:0] SEL_GROUND = 5'h1f;
    localparam logic [4:0] OUT_NULL = 5'h00;

    localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
    localparam int LOCK_BIT = 6;
    localparam int FUSE_BIT = 5;

    localparam int IRQ_MISMATCH = 0;
    localparam int IRQ_LOCK_REFUSED = 1;
    localparam int IRQ_W = 2;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    typedef enum logic [1:0] {
        PRP_KEY_IDLE,
        PRP_KEY_ONE,
        PRP_KEY_OPEN
    } prp_key_state_t;

    typedef struct packed {
        logic [11:0] addr;
        logic write;
    } prp_bus_req_t;

    typedef struct packed {
        logic [NUM_PIN-1:0] analog_en;
        logic [NUM_PIN-1:0] dir_out;
    } prp_pin_ctrl_t;
endpackage

/* src/prp_top.sv */
// Pin remap protection, selection and shared pin logic with AHB-Lite registers.
//
// The AHB-Lite slave port and the address map were left to the implementer.
module prp_top
    import prp_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Configuration fuse, one when unprogrammed
    input wire logic one_way_lock_fuse,
    // Remappable and shared pins
    input wire logic [NUM_PIN-1:0] pin_in,
    input wire logic [NUM_PIN-1:0] direction_reg,
    output logic [NUM_PIN-1:0] pin_dig_in,
    output logic [NUM_PIN-1:0] pin_input_buf_en,
    output logic [NUM_PIN-1:0] pin_pullup_en,
    // Peripheral input and output routing
    input wire logic [31:0] periph_out,
    output logic [NUM_IN_SEL*2-1:0] periph_in,
    output logic [NUM_OUT_SEL*2-1:0] rp_out,
    // Per-pin function enables, index 0 highest priority
    output logic [NUM_PIN*NUM_FUNC-1:0] func_grant,
    // Status
    output logic config_mismatch_rst,
    output logic pin_map_lock,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    prp_bus_req_t req_q;
    logic req_valid_q;
    logic [15:0] in_sel_q [NUM_IN_SEL];
    logic [15:0] in_shadow_q [NUM_IN_SEL];
    logic [15:0] out_sel_q [NUM_OUT_SEL];
    logic [15:0] out_shadow_q [NUM_OUT_SEL];
    logic [NUM_PIN-1:0] ana_cfg_q [NUM_ADC];
    logic [NUM_PIN-1:0] pullup_q;
    logic [NUM_PIN-1:0] func_en_q [NUM_FUNC];
    logic [IRQ_W-1:0] irq_stat_q, irq_mask_q;
    logic lock_q, ever_locked_q, mismatch_q;
    logic [NUM_PIN-1:0] pin_s1_q, pin_s2_q;
    logic fuse_s1_q, fuse_s2_q;
    prp_key_state_t key_q;
    logic [31:0] rdata_q;

    logic wr_en, rd_en, osc_wr, lock_req, lock_ok, lock_refused;
    logic mismatch_now;
    logic [NUM_PIN-1:0] digital;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        return a == o;
    endfunction

    // Maps a byte address into a register index within a block of words.
    function automatic int idx(input logic [11:0] a, input logic [11:0] base);
        return int'((a - base) >> 2);
    endfunction

    function automatic logic in_blk(input logic [11:0] a,
                                    input logic [11:0] base,
                                    input int n);
        return a >= base && a < base + 12'(4 * n);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Zero-wait-state slave: address phase captured, data phase next cycle.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_valid_q <= 1'b0;
            req_q <= '0;
        end else if (hready) begin
            req_valid_q <= hsel && htrans == HTRANS_NONSEQ;
            req_q <= '{addr: haddr[11:0], write: hwrite};
        end
    end

    assign wr_en = req_valid_q && req_q.write;
    assign rd_en = hsel && htrans == HTRANS_NONSEQ && !hwrite && hready;
    assign osc_wr = wr_en && hit(req_q.addr, OSC_CTRL_OFS);

    ////////////////////////////////////////////////////////////////////////
    // Unlock sequence; any other bus write between the steps aborts it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_q <= PRP_KEY_IDLE;
        end else if (wr_en) begin
            case (key_q)
                PRP_KEY_IDLE:
                    key_q <= (osc_wr && hwdata[7:0] == UNLOCK_KEY1) ?
                             PRP_KEY_ONE : PRP_KEY_IDLE;
                PRP_KEY_ONE:
                    key_q <= (osc_wr && hwdata[7:0] == UNLOCK_KEY2) ?
                             PRP_KEY_OPEN : PRP_KEY_IDLE;
                PRP_KEY_OPEN: key_q <= PRP_KEY_IDLE;
                default: key_q <= PRP_KEY_IDLE;
            endcase
        end
    end

    assign lock_req = osc_wr && key_q == PRP_KEY_OPEN;
    // A clear after the first lock is refused while the fuse is set.
    assign lock_ok = lock_req &&
                     !(hwdata[LOCK_BIT] == 1'b0 && ever_locked_q &&
                       fuse_s2_q);
    assign lock_refused = lock_req && !lock_ok;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fuse_s1_q <= 1'b1;
            fuse_s2_q <= 1'b1;
        end else begin
            fuse_s1_q <= one_way_lock_fuse;
            fuse_s2_q <= fuse_s1_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_q <= 1'b0;
            ever_locked_q <= 1'b0;
        end else if (lock_ok) begin
            lock_q <= hwdata[LOCK_BIT];
            ever_locked_q <= ever_locked_q | hwdata[LOCK_BIT];
        end
    end
    assign pin_map_lock = lock_q;

    ////////////////////////////////////////////////////////////////////////
    // Select registers and shadows are written together on accepted writes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_IN_SEL; i++) begin
                in_sel_q[i] <= (i == 0) ? IN_SEL0_MASK : IN_SEL_RST;
                in_shadow_q[i] <= (i == 0) ? IN_SEL0_MASK : IN_SEL_RST;
            end
            for (int i = 0; i < NUM_OUT_SEL; i++) begin
                out_sel_q[i] <= OUT_SEL_RST;
                out_shadow_q[i] <= OUT_SEL_RST;
            end
        end else if (wr_en && !lock_q) begin
            if (in_blk(req_q.addr, IN_SEL_BASE, NUM_IN_SEL)) begin
                in_sel_q[idx(req_q.addr, IN_SEL_BASE)] <=
                    hwdata[15:0] & ((req_q.addr == IN_SEL_BASE) ?
                    IN_SEL0_MASK : IN_SEL_MASK);
                in_shadow_q[idx(req_q.addr, IN_SEL_BASE)] <=
                    hwdata[15:0] & ((req_q.addr == IN_SEL_BASE) ?
                    IN_SEL0_MASK : IN_SEL_MASK);
            end
            if (in_blk(req_q.addr, OUT_SEL_BASE, NUM_OUT_SEL)) begin
                out_sel_q[idx(req_q.addr, OUT_SEL_BASE)] <=
                    hwdata[15:0] & OUT_SEL_MASK;
                out_shadow_q[idx(req_q.addr, OUT_SEL_BASE)] <=
                    hwdata[15:0] & OUT_SEL_MASK;
            end
        end
    end

    // Any difference not explained by a write is a disturbance of a cell.
    always_comb begin
        mismatch_now = 1'b0;
        for (int i = 0; i < NUM_IN_SEL; i++)
            mismatch_now |= in_sel_q[i] != in_shadow_q[i];
        for (int i = 0; i < NUM_OUT_SEL; i++)
            mismatch_now |= out_sel_q[i] != out_shadow_q[i];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mismatch_q <= 1'b0;
        end else begin
            mismatch_q <= mismatch_now;
        end
    end
    assign config_mismatch_rst = mismatch_q;

    ////////////////////////////////////////////////////////////////////////
    // Other control registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_ADC; i++)
                ana_cfg_q[i] <= '0;
            for (int i = 0; i < NUM_FUNC; i++)
                func_en_q[i] <= '0;
            pullup_q <= '0;
            irq_mask_q <= '0;
        end else if (wr_en) begin
            if (hit(req_q.addr, ANA_CFG0_OFS))
                ana_cfg_q[0] <= hwdata[NUM_PIN-1:0];
            if (hit(req_q.addr, ANA_CFG1_OFS))
                ana_cfg_q[1] <= hwdata[NUM_PIN-1:0];
            if (hit(req_q.addr, PULLUP_OFS))
                pullup_q <= hwdata[NUM_PIN-1:0];
            if (in_blk(req_q.addr, FUNC_EN_BASE, NUM_FUNC))
                func_en_q[idx(req_q.addr, FUNC_EN_BASE)] <=
                    hwdata[NUM_PIN-1:0];
            if (hit(req_q.addr, IRQ_MASK_OFS))
                irq_mask_q <= hwdata[IRQ_W-1:0];
        end
    end

    // Set wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q &
                ~((wr_en && hit(req_q.addr, IRQ_STAT_OFS)) ?
                  hwdata[IRQ_W-1:0] : '0)) |
                {lock_refused, mismatch_now && !mismatch_q};
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////
    // Pin side.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    assign digital = ana_cfg_q[0] & ana_cfg_q[1];
    assign pin_input_buf_en = digital;
    assign pin_pullup_en = pullup_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_dig_in <= '0;
        end else begin
            pin_dig_in <= pin_s2_q & digital;
        end
    end

    // Function enables compete per pin and function 0 wins; output drive is left alone.
    always_comb begin
        logic [NUM_PIN-1:0] taken;
        taken = '0;
        func_grant = '0;
        for (int f = 0; f < NUM_FUNC; f++) begin
            for (int p = 0; p < NUM_PIN; p++) begin
                func_grant[p*NUM_FUNC+f] = func_en_q[f][p] && !taken[p];
            end
            taken |= func_en_q[f];
        end
    end

    // Output routing per pin; direction bits still gate the driver.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rp_out <= '0;
            periph_in <= '0;
        end else begin
            for (int i = 0; i < NUM_OUT_SEL*2; i++) begin
                rp_out[i] <= (out_sel_q[i/2][(i%2)*8 +: FIELD_W] == OUT_NULL) ?
                    1'b0 :
                    periph_out[out_sel_q[i/2][(i%2)*8 +: FIELD_W]] &&
                    !direction_reg[i];
            end
            for (int i = 0; i < NUM_IN_SEL*2; i++) begin
                // The low byte of the first select has no field to route.
                periph_in[i] <= (i == 0 ||
                    in_sel_q[i/2][(i%2)*8 +: FIELD_W] == SEL_GROUND) ?
                    1'b0 :
                    pin_s2_q[in_sel_q[i/2][(i%2)*8 +: FIELD_W]] &&
                    digital[in_sel_q[i/2][(i%2)*8 +: FIELD_W]];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, registered for the data phase; unmapped reads zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= '0;
        end else if (rd_en) begin
            rdata_q <= '0;
            if (in_blk(haddr[11:0], IN_SEL_BASE, NUM_IN_SEL))
                rdata_q <= {16'h0000,
                    in_sel_q[idx(haddr[11:0], IN_SEL_BASE)]};
            if (in_blk(haddr[11:0], OUT_SEL_BASE, NUM_OUT_SEL))
                rdata_q <= {16'h0000,
                    out_sel_q[idx(haddr[11:0], OUT_SEL_BASE)]};
            if (hit(haddr[11:0], OSC_CTRL_OFS))
                rdata_q <= 32'(lock_q) << LOCK_BIT |
                           32'(fuse_s2_q) << FUSE_BIT;
            if (hit(haddr[11:0], ANA_CFG0_OFS))
                rdata_q <= ana_cfg_q[0];
            if (hit(haddr[11:0], ANA_CFG1_OFS))
                rdata_q <= ana_cfg_q[1];
            if (hit(haddr[11:0], PULLUP_OFS))
                rdata_q <= pullup_q;
            if (in_blk(haddr[11:0], FUNC_EN_BASE, NUM_FUNC))
                rdata_q <= func_en_q[idx(haddr[11:0], FUNC_EN_BASE)];
            if (hit(haddr[11:0], IRQ_STAT_OFS))
                rdata_q <= 32'(irq_stat_q);
            if (hit(haddr[11:0], IRQ_MASK_OFS))
                rdata_q <= 32'(irq_mask_q);
            if (hit(haddr[11:0], PIN_IN_OFS))
                rdata_q <= pin_dig_in;
        end
    end

endmodule

/* tb/prp_chk.sv */
// Checker of the pin remap protection block, bound to its top module.
module prp_chk
    import prp_pkg::*;
(
    // Clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins and status
    input wire logic one_way_lock_fuse,
    input wire logic [NUM_PIN-1:0] pin_dig_in,
    input wire logic [NUM_PIN-1:0] pin_input_buf_en,
    input wire logic [NUM_IN_SEL*2-1:0] periph_in,
    input wire logic [NUM_PIN*NUM_FUNC-1:0] func_grant,
    input wire logic config_mismatch_rst,
    input wire logic pin_map_lock
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic osc_wr_q;
    logic multi_grant;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_wr_q <= 1'b0;
        end else begin
            osc_wr_q <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite
                && haddr[11:0] == OSC_CTRL_OFS;
        end
    end
    always_comb begin
        multi_grant = 1'b0;
        for (int p = 0; p < NUM_PIN; p++) begin
            if ($countones(func_grant[p*NUM_FUNC +: NUM_FUNC]) > 1) begin
                multi_grant = 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus stalled or answered with an error");
    a_no_mismatch: assert property (!config_mismatch_rst)
        else $error("mismatch reset without a fault");
    a_lock_by_write: assert property (
        $changed(pin_map_lock) |-> $past(osc_wr_q))
        else $error("lock changed without a control write");
    a_one_way_hold: assert property (
        $fell(pin_map_lock) |-> !$past(one_way_lock_fuse, 3))
        else $error("lock cleared while the fuse was set");
    a_sel0_low_zero: assert property (periph_in[0] == 1'b0)
        else $error("unimplemented select bits not zero");
    a_locked_stable: assert property (
        pin_map_lock && $past(pin_map_lock) |=> $stable(periph_in))
        else $error("input routing changed while locked");
    a_analog_off: assert property ((pin_dig_in & ~pin_input_buf_en
        & ~$past(pin_input_buf_en) & ~$past(pin_input_buf_en, 2)) == '0)
        else $error("analog pin read as one");
    a_grant_single: assert property (!multi_grant)
        else $error("two functions granted on one pin");
    a_analog_reset: assert property (
        $rose(hresetn) |-> pin_input_buf_en == '0)
        else $error("shared pin digital after reset");
endmodule
bind prp_top prp_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp),
    .one_way_lock_fuse(one_way_lock_fuse), .pin_dig_in(pin_dig_in),
    .pin_input_buf_en(pin_input_buf_en), .periph_in(periph_in),
    .func_grant(func_grant), .config_mismatch_rst(config_mismatch_rst),
    .pin_map_lock(pin_map_lock));

/* tb/prp_periph_model.sv */
// Model of the remappable pins and of the peripherals that drive them.
module prp_periph_model
    import prp_pkg::*;
(
    // Pattern chosen by the bench
    input wire logic [NUM_PIN-1:0] level,
    // Pin levels and peripheral outputs
    output logic [NUM_PIN-1:0] pin_in,
    output logic [31:0] periph_out
);
    // Peripheral outputs differ from the pin levels so routing is visible.
    assign pin_in = level;
    assign periph_out = {level[15:0], level[31:16]};
endmodule

/* tb/prp_top_tb.sv */
// Self-checking testbench of the pin remap protection block.
module prp_top_tb
    import prp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic fuse = 1'b1;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = '0, hwdata = '0, rd, v[17], a, b;
    logic [31:0] dir = '1, level = '0, fe[NUM_FUNC];
    logic hreadyout, hresp, lock, irq, mism;
    logic [31:0] hrdata, pin_in, dig, bufen, pull, pout;
    logic [17:0] pin_sel;
    logic [15:0] rp_out;
    logic [127:0] grant;
    logic [3:0] en;
    int err_count = 0;
    int compares = 0;
    prp_periph_model u_model (.level(level), .pin_in(pin_in),
        .periph_out(pout));
    prp_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .one_way_lock_fuse(fuse),
        .pin_in(pin_in), .direction_reg(dir), .pin_dig_in(dig),
        .pin_input_buf_en(bufen), .pin_pullup_en(pull), .periph_out(pout),
        .periph_in(pin_sel), .rp_out(rp_out), .func_grant(grant),
        .config_mismatch_rst(mism), .pin_map_lock(lock), .irq(irq));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 hclk = ~hclk;
    end
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // The master waits on hready itself and never assumes a latency.
    task automatic xfer(input logic w, input logic [11:0] ad,
                        input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {20'h0, ad};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        // Let the data-phase edge settle before anyone looks at outputs.
        #1;
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        xfer(1'b1, ad, d);
    endtask
    task automatic rdc(input string nm, input logic [11:0] ad,
                       input logic [31:0] e, input logic [31:0] m);
        xfer(1'b0, ad, 32'h0);
        chk(nm, e, rd & m);
    endtask
    task automatic unlock(input logic [31:0] d);
        wr(OSC_CTRL_OFS, {24'h0, UNLOCK_KEY1});
        wr(OSC_CTRL_OFS, {24'h0, UNLOCK_KEY2});
        wr(OSC_CTRL_OFS, d);
    endtask
    task automatic do_reset(input logic f);
        hresetn <= 1'b0;
        fuse <= f;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
    endtask
    function automatic logic [3:0] first_on(input logic [3:0] e);
        return e & (~e + 4'h1);
    endfunction
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        final_report;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(25));
        do_reset(1'b1);
        rdc("in_sel0", IN_SEL_BASE, 32'h1f00, '1);
        rdc("in_sel1", IN_SEL_BASE + 12'h4, 32'h1f1f, '1);
        rdc("out_sel0", OUT_SEL_BASE, 32'h0, '1);
        rdc("fuse_bit", OSC_CTRL_OFS, 32'h20, 32'h60);
        rdc("unmapped", 12'hffc, 32'h0, '1);
        chk("buf_en_rst", 32'h0, bufen);
        for (int i = 0; i < 17; i++) begin
            v[i] = $urandom;
            wr(i < 9 ? IN_SEL_BASE + 12'(4 * i) : OUT_SEL_BASE + 12'(4 * i - 36), v[i]);
        end
        for (int i = 0; i < 17; i++) begin
            a = i == 0 ? {16'h0, IN_SEL0_MASK} : i < 9 ? {16'h0, IN_SEL_MASK}
                : {16'h0, OUT_SEL_MASK};
            rdc("sel_reg", i < 9 ? IN_SEL_BASE + 12'(4 * i)
                : OUT_SEL_BASE + 12'(4 * i - 36), v[i] & a, '1);
        end
        wr(ANA_CFG0_OFS, 32'hffff_ffff);
        wr(ANA_CFG1_OFS, 32'hffff_ffff);
        level <= $urandom;
        repeat (3) @(posedge hclk);
        foreach (v[k]) begin
            if (k < 3) begin
                a = k == 0 ? 32'h19 : k == 1 ? 32'h0 : 32'h1f;
                wr(IN_SEL_BASE, {16'h0, a[7:0], 8'hff});
                repeat (3) @(posedge hclk);
                b = a == 32'h1f ? 32'h0 : 32'(level[a[4:0]]);
                chk("int1_route", b, 32'(pin_sel[1]));
            end
        end
        unlock(32'h40);
        chk("lock_set", 32'h1, 32'(lock));
        wr(IN_SEL_BASE, 32'h0300);
        rdc("locked_wr", IN_SEL_BASE, 32'h1f00, '1);
        wr(IRQ_MASK_OFS, 32'h2);
        unlock(32'h0);
        chk("lock_kept", 32'h1, 32'(lock));
        chk("irq_on", 32'h1, 32'(irq));
        wr(IRQ_STAT_OFS, 32'h2);
        chk("irq_off", 32'h0, 32'(irq));
        do_reset(1'b0);
        wr(OSC_CTRL_OFS, {24'h0, UNLOCK_KEY2});
        wr(OSC_CTRL_OFS, 32'h40);
        chk("bad_key", 32'h0, 32'(lock));
        unlock(32'h40);
        unlock(32'h0);
        chk("relock", 32'h0, 32'(lock));
        unlock(32'h40);
        unlock(32'h0);
        chk("relock2", 32'h0, 32'(lock));
        a = $urandom;
        b = $urandom;
        wr(ANA_CFG0_OFS, a);
        wr(ANA_CFG1_OFS, b);
        chk("buf_en", a & b, bufen);
        level <= $urandom;
        repeat (4) @(posedge hclk);
        chk("dig_in", level & a & b, dig);
        a = $urandom;
        wr(PULLUP_OFS, a);
        chk("pullup", a, pull);
        foreach (fe[f]) begin
            fe[f] = $urandom;
            wr(FUNC_EN_BASE + 12'(4 * f), fe[f]);
        end
        for (int p = 0; p < NUM_PIN; p++) begin
            en = {fe[3][p], fe[2][p], fe[1][p], fe[0][p]};
            chk("grant", 32'(first_on(en)), 32'(grant[p*4 +: 4]));
        end
        wr(ANA_CFG0_OFS, 32'h0);
        dir <= 32'h0;
        level <= 32'h0008_0000 | $urandom;
        wr(OUT_SEL_BASE, 32'h0003);
        repeat (3) @(posedge hclk);
        chk("rp_out", {31'h0, pout[3]}, 32'(rp_out[1:0]));
        final_report;
    end
endmodule
